// *** logic/charge_ctl_pkg.sv ***
// constants for the charge state controller
// assumes a 250 MHz core clock and comparator results as single bits
package charge_ctl_pkg;

  // clock rate in kHz
  localparam int unsigned CLK_KHZ        = 250_000;
  // constant-voltage pause period, seconds
  localparam int unsigned CV_PERIOD_S    = 30;
  localparam longint unsigned CV_PERIOD_CYC =
    longint'(CV_PERIOD_S) * longint'(CLK_KHZ) * 64'd1000;
  // blink at 0.5 Hz: toggle every second
  localparam int unsigned BLINK_HALF_MS  = 1000;
  localparam longint unsigned BLINK_HALF_CYC =
    longint'(BLINK_HALF_MS) * longint'(CLK_KHZ);
  // pause length before sampling feedback, microseconds
  localparam int unsigned PAUSE_US       = 100;
  localparam int unsigned PAUSE_CYC      = PAUSE_US * (CLK_KHZ / 1000);

  // current command codes
  localparam logic [2:0] CUR_OFF         = 3'h0;
  localparam logic [2:0] CUR_TRICKLE     = 3'h1;
  localparam logic [2:0] CUR_BATT_SET    = 3'h2;
  localparam logic [2:0] CUR_INPUT_SET   = 3'h3;

  // led variant codes
  localparam logic [1:0] LED_BLINK       = 2'h0;
  localparam logic [1:0] LED_ON_CHARGING = 2'h1;

  // charge states, one-hot
  typedef enum logic [5:0] {
    ST_STANDBY = 6'b00_0001,
    ST_PRE     = 6'b00_0010,
    ST_CC      = 6'b00_0100,
    ST_CV      = 6'b00_1000,
    ST_PAUSE   = 6'b01_0000,
    ST_FULL    = 6'b10_0000
  } chg_state_t;

endpackage

// *** logic/sense_sync.sv ***
// two-flop synchroniser for a bundle of comparator results
// assumes the inputs are asynchronous levels from analog comparators
`timescale 1ns/1ns
module sense_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             reset_n,
  // raw and synchronised levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // first stage, read only by the second stage
  logic [WIDTH-1:0] meta_q;

  // ---------------------------------------------------------------
  // two flip-flops per bit
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// *** logic/battery_charge_state_control.sv ***
// charge state controller of a step-down lithium charger
// assumes analog comparators give one bit per threshold; the variant
// threshold selects (iron-phosphate) are done in the analog front end
// What this block does
// - below trickle limit: precharge, trickle current
// - between limits: constant current, set current
// - above full: cv, pause every 30 s
// - pause still above full: declare full, else resume
// - full and below recharge: restart charging
// - cc current is smaller of two settings
// - floating current set pin: no current
// - normal zone charges, above 45 half
// - above 60 degrees: stop charging
// - thermistor zones from threshold comparators
// - input sense low: throttle current
// - input sense below 1.3 V: standby
// - led variant: on charging, off full
// - ovs variant: input sense overvoltage stops
// - lfp variant: thresholds 1.8 and 1.35
// - default led: blink charging, on full
// - input over 27 V stop, 25 V restart (ovs variant off)
`timescale 1ns/1ns
module battery_charge_state_control #(
  parameter longint unsigned CV_PERIOD  = charge_ctl_pkg::CV_PERIOD_CYC,
  parameter longint unsigned BLINK_HALF = charge_ctl_pkg::BLINK_HALF_CYC,
  parameter int unsigned     PAUSE_LEN  = charge_ctl_pkg::PAUSE_CYC
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       reset_n,
  // feedback comparators
  input  wire logic       fb_above_trickle,
  input  wire logic       fb_above_full,
  input  wire logic       fb_above_recharge,
  // thermistor comparators (high = temperature inside the zone limit)
  input  wire logic       ntc_above_cold,
  input  wire logic       ntc_above_warm,
  input  wire logic       ntc_above_hot,
  // input sense and vin comparators
  input  wire logic       input_sense_above_reg,
  input  wire logic       input_sense_above_uvlo,
  input  wire logic       input_sense_above_ov,
  input  wire logic       vin_above_ov_trip,
  input  wire logic       vin_above_ov_release,
  // current setting pin open detectors
  input  wire logic       battery_current_set_open,
  input  wire logic       input_current_set_open,
  // smaller-setting comparator: battery setting is the lower one
  input  wire logic       battery_cc_current_lower,
  // variant straps, static
  input  wire logic       led_variant_on_charging,
  input  wire logic       ovs_variant,
  // outputs to power stage and indicator
  output logic [2:0]      current_cmd,
  output logic            half_current,
  output logic            throttle_input,
  output logic            led_on,
  output logic            charge_full,
  output logic            standby,
  output logic            ntc_source_en
);

  // ---------------------------------------------------------------
  // synchronised comparator bundle
  // ---------------------------------------------------------------
  localparam int unsigned NSENSE = 16;
  logic [NSENSE-1:0] raw_in;
  logic [NSENSE-1:0] syn;

  assign raw_in = {fb_above_trickle, fb_above_full, fb_above_recharge,
                   ntc_above_cold, ntc_above_warm, ntc_above_hot,
                   input_sense_above_reg, input_sense_above_uvlo,
                   input_sense_above_ov, vin_above_ov_trip,
                   vin_above_ov_release, battery_current_set_open,
                   input_current_set_open, battery_cc_current_lower,
                   ovs_variant, led_variant_on_charging};

  // every analog result passes two flops first
  sense_sync #(.WIDTH(NSENSE)) u_sync (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .async_in (raw_in),
    .sync_out (syn)
  );

  // named views of the synchronised bits
  logic fb_trk, fb_full, fb_rch;
  logic t_cold_ok, t_warm_ok, t_hot_ok;
  logic in_reg, in_uvlo, in_ov, vin_trip, vin_rel;
  logic bset_open, iset_open, batt_lower, ovs, led_var_s;

  // feedback bits carry the variant thresholds set in the front end
  assign {fb_trk, fb_full, fb_rch, t_cold_ok, t_warm_ok, t_hot_ok,
          in_reg, in_uvlo, in_ov, vin_trip, vin_rel, bset_open,
          iset_open, batt_lower, ovs, led_var_s} = syn;

  // ---------------------------------------------------------------
  // thermistor zones
  // ---------------------------------------------------------------
  // thermistor voltage falls as temperature rises
  logic too_cold;   // below -10 degrees
  logic too_hot;    // above 60 degrees
  logic warm_zone;  // above 45, up to 60 degrees
  logic cold_hold_q;

  assign too_cold  = !t_cold_ok;
  assign too_hot   = !t_hot_ok;
  assign warm_zone = !t_warm_ok && t_hot_ok;
  assign ntc_source_en = reset_n;

  // cold stop latches until the normal zone is reached again
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cold_hold_q <= 1'b0;
    end else if (too_cold && t_warm_ok) begin
      // a real cold reading also passes the warm limit; the all-low
      // pattern out of reset must not latch a cold stop
      cold_hold_q <= 1'b1;
    end else if (t_warm_ok) begin
      cold_hold_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // input overvoltage, with hysteresis when ovs is off
  // ---------------------------------------------------------------
  logic vin_ov_q;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      vin_ov_q <= 1'b0;
    end else if (ovs) begin
      vin_ov_q <= in_ov;
    end else if (vin_trip) begin
      vin_ov_q <= 1'b1;
    end else if (!vin_rel) begin
      vin_ov_q <= 1'b0;
    end
  end

  // thermal or input overvoltage reason to hold current at zero
  logic inhibit;
  assign inhibit = too_hot || cold_hold_q || vin_ov_q;

  // ---------------------------------------------------------------
  // cv period timer and pause timer
  // ---------------------------------------------------------------
  charge_ctl_pkg::chg_state_t state_q, state_d;
  logic [63:0] cv_cnt_q;
  logic [31:0] pause_cnt_q;
  logic        cv_tick;
  logic        pause_done;

  assign cv_tick    = (cv_cnt_q == CV_PERIOD - 64'd1);
  assign pause_done = (pause_cnt_q == PAUSE_LEN - 32'd1);

  // counts only in cv; restarts on every entry
  always_ff @(posedge mclk) begin
    if (!reset_n || state_q != charge_ctl_pkg::ST_CV) begin
      cv_cnt_q <= 64'h0000_0000_0000_0000;
    end else if (cv_tick) begin
      cv_cnt_q <= 64'h0000_0000_0000_0000;
    end else begin
      cv_cnt_q <= cv_cnt_q + 64'd1;
    end
  end

  // settle time with current off before sampling feedback
  always_ff @(posedge mclk) begin
    if (!reset_n || state_q != charge_ctl_pkg::ST_PAUSE) begin
      pause_cnt_q <= 32'h0000_0000;
    end else if (!pause_done) begin
      pause_cnt_q <= pause_cnt_q + 32'd1;
    end
  end

  // ---------------------------------------------------------------
  // charge state machine
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      charge_ctl_pkg::ST_STANDBY: begin
        if (in_uvlo) state_d = charge_ctl_pkg::ST_PRE;
      end
      charge_ctl_pkg::ST_PRE: begin
        if (fb_trk) state_d = charge_ctl_pkg::ST_CC;
      end
      charge_ctl_pkg::ST_CC: begin
        if (!fb_trk) state_d = charge_ctl_pkg::ST_PRE;
        else if (fb_full) state_d = charge_ctl_pkg::ST_CV;
      end
      charge_ctl_pkg::ST_CV: begin
        if (cv_tick) state_d = charge_ctl_pkg::ST_PAUSE;
      end
      charge_ctl_pkg::ST_PAUSE: begin
        if (pause_done) begin
          if (fb_full) state_d = charge_ctl_pkg::ST_FULL;
          else state_d = charge_ctl_pkg::ST_CC;
        end
      end
      charge_ctl_pkg::ST_FULL: begin
        if (!fb_rch) state_d = charge_ctl_pkg::ST_PRE;
      end
      default: state_d = charge_ctl_pkg::ST_STANDBY;
    endcase
    // undervoltage overrides every state
    if (!in_uvlo) state_d = charge_ctl_pkg::ST_STANDBY;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_q <= charge_ctl_pkg::ST_STANDBY;
    end else begin
      state_q <= state_d;
    end
  end

  // ---------------------------------------------------------------
  // current command
  // ---------------------------------------------------------------
  logic charging;
  assign charging = state_q inside {charge_ctl_pkg::ST_PRE,
                                    charge_ctl_pkg::ST_CC,
                                    charge_ctl_pkg::ST_CV};

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      current_cmd    <= charge_ctl_pkg::CUR_OFF;
      half_current   <= 1'b0;
      throttle_input <= 1'b0;
    end else begin
      half_current   <= warm_zone;
      // below the regulation point the loop backs off current
      throttle_input <= charging && !in_reg;
      if (!charging || inhibit || bset_open || iset_open) begin
        current_cmd <= charge_ctl_pkg::CUR_OFF;
      end else if (state_q == charge_ctl_pkg::ST_PRE) begin
        current_cmd <= charge_ctl_pkg::CUR_TRICKLE;
      end else if (batt_lower) begin
        current_cmd <= charge_ctl_pkg::CUR_BATT_SET;
      end else begin
        current_cmd <= charge_ctl_pkg::CUR_INPUT_SET;
      end
    end
  end

  // ---------------------------------------------------------------
  // status and indicator
  // ---------------------------------------------------------------
  logic [63:0] blink_cnt_q;
  logic        blink_q;

  // half-period divider for the 0.5 Hz blink
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      blink_cnt_q <= 64'h0000_0000_0000_0000;
      blink_q     <= 1'b0;
    end else if (blink_cnt_q == BLINK_HALF - 64'd1) begin
      blink_cnt_q <= 64'h0000_0000_0000_0000;
      blink_q     <= !blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 64'd1;
    end
  end

  logic in_charge, is_full;
  assign in_charge = charging || state_q == charge_ctl_pkg::ST_PAUSE;
  assign is_full   = (state_q == charge_ctl_pkg::ST_FULL);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      led_on      <= 1'b0;
      charge_full <= 1'b0;
      standby     <= 1'b1;
    end else begin
      charge_full <= is_full;
      standby     <= (state_q == charge_ctl_pkg::ST_STANDBY);
      if (led_var_s) begin
        led_on <= in_charge;
      end else begin
        led_on <= is_full || (in_charge && blink_q);
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  floating_pin_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (bset_open || iset_open) |=> current_cmd == charge_ctl_pkg::CUR_OFF)
    else $error("current with floating set pin");
  standby_uvlo_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !in_uvlo |=> state_q == charge_ctl_pkg::ST_STANDBY)
    else $error("no standby on undervoltage");
  hot_stop_a: assert property (@(posedge mclk) disable iff (!reset_n)
    too_hot |=> current_cmd == charge_ctl_pkg::CUR_OFF)
    else $error("charging while hot");
  pause_full_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (state_q == charge_ctl_pkg::ST_PAUSE && pause_done && fb_full
     && in_uvlo) |=> state_q == charge_ctl_pkg::ST_FULL)
    else $error("full not declared");
  recharge_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (is_full && !fb_rch && in_uvlo) |=> state_q == charge_ctl_pkg::ST_PRE)
    else $error("no recharge");
  cv_pause_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (state_q == charge_ctl_pkg::ST_CV && cv_tick && in_uvlo)
    |=> state_q == charge_ctl_pkg::ST_PAUSE ##1
        current_cmd == charge_ctl_pkg::CUR_OFF)
    else $error("cv pause missed");
  trickle_cmd_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (state_q == charge_ctl_pkg::ST_PRE && !inhibit && !bset_open
     && !iset_open) |=> current_cmd == charge_ctl_pkg::CUR_TRICKLE)
    else $error("no trickle in precharge");
  min_current_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (state_q == charge_ctl_pkg::ST_CC && !inhibit && !bset_open
     && !iset_open && batt_lower)
    |=> current_cmd == charge_ctl_pkg::CUR_BATT_SET)
    else $error("wrong cc source");
  cold_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
    cold_hold_q |=> current_cmd == charge_ctl_pkg::CUR_OFF)
    else $error("charging while cold latched");
  half_warm_a: assert property (@(posedge mclk) disable iff (!reset_n)
    warm_zone |=> half_current)
    else $error("no half current when warm");

endmodule

// *** tb/charge_env_model.sv ***
// far-side model: battery pack, thermistor and adapter seen as comparators
// assumes the bench sets physical levels in millivolts and degrees
`timescale 1ns/1ns
module charge_env_model (
  // physical levels set by the bench
  input  int   fb_mv,
  input  int   temp_c,
  input  int   sense_mv,
  input  int   vin_mv,
  // iron-phosphate variant of the feedback thresholds
  input  logic lfp,
  // thermistor bias from the controller
  input  logic ntc_source_en,
  // feedback comparators
  output logic fb_above_trickle,
  output logic fb_above_full,
  output logic fb_above_recharge,
  // thermistor comparators, high reads as inside the zone limit
  output logic ntc_above_cold,
  output logic ntc_above_warm,
  output logic ntc_above_hot,
  // input side comparators
  output logic input_sense_above_reg,
  output logic input_sense_above_uvlo,
  output logic input_sense_above_ov,
  output logic vin_above_ov_trip,
  output logic vin_above_ov_release
);
  // ---------------------------------------------------------------
  // feedback divider thresholds, standard or iron-phosphate chemistry
  // ---------------------------------------------------------------
  assign fb_above_trickle  = (fb_mv > (lfp ? 1350 : 1500));
  assign fb_above_full     = (fb_mv > (lfp ? 1800 : 2075));
  assign fb_above_recharge = (fb_mv > 2050);
  // ---------------------------------------------------------------
  // thermistor node: without bias current it sits at ground, which
  // looks hotter than any zone, so a dead source never reads as safe
  // ---------------------------------------------------------------
  assign ntc_above_cold = ntc_source_en ? (temp_c >= -10) : 1'b1;
  assign ntc_above_warm = ntc_source_en && (temp_c <= 45);
  assign ntc_above_hot  = ntc_source_en && (temp_c <= 60);
  // ---------------------------------------------------------------
  // adapter side: sense pin doubles as an enable driven from outside
  // ---------------------------------------------------------------
  assign input_sense_above_reg  = (sense_mv > 1500);
  assign input_sense_above_uvlo = (sense_mv > 1300);
  assign input_sense_above_ov   = (sense_mv > 2600);
  assign vin_above_ov_trip      = (vin_mv > 27000);
  assign vin_above_ov_release   = (vin_mv > 25000);
endmodule

// *** tb/battery_charge_state_control_tb.sv ***
// self-checking bench for the charge state controller
// assumes shortened timer parameters and the comparator model beside it
`timescale 1ns/1ns
module battery_charge_state_control_tb;
  // shortened timers, expectations derive from these
  localparam int CV_P = 200;
  localparam int BLINK = 10;
  // clock, reset and bench-driven levels
  logic       mclk;
  logic       reset_n;
  int         fb_mv, temp_c, sense_mv, vin_mv;
  logic       bset_open, iset_open, batt_lower, led_var, ovs_var, lfp;
  // comparator wires between model and controller
  logic       fb_tr, fb_fu, fb_rc, n_c, n_w, n_h;
  logic       s_reg, s_uv, s_ov, v_trip, v_rel;
  // controller outputs
  logic [2:0] current_cmd;
  logic       half_current, throttle_input, led_on;
  logic       charge_full, standby, ntc_source_en;
  // bookkeeping
  int         fail_count, num_checks, ones, togs, paused;

  charge_env_model env (.fb_mv(fb_mv), .temp_c(temp_c), .lfp(lfp),
    .sense_mv(sense_mv), .vin_mv(vin_mv), .ntc_source_en(ntc_source_en),
    .fb_above_trickle(fb_tr), .fb_above_full(fb_fu),
    .fb_above_recharge(fb_rc), .ntc_above_cold(n_c), .ntc_above_warm(n_w),
    .ntc_above_hot(n_h), .input_sense_above_reg(s_reg),
    .input_sense_above_uvlo(s_uv), .input_sense_above_ov(s_ov),
    .vin_above_ov_trip(v_trip), .vin_above_ov_release(v_rel));

  battery_charge_state_control #(.CV_PERIOD(CV_P), .BLINK_HALF(BLINK),
    .PAUSE_LEN(4)) dut (.mclk(mclk), .reset_n(reset_n),
    .fb_above_trickle(fb_tr), .fb_above_full(fb_fu),
    .fb_above_recharge(fb_rc), .ntc_above_cold(n_c), .ntc_above_warm(n_w),
    .ntc_above_hot(n_h), .input_sense_above_reg(s_reg),
    .input_sense_above_uvlo(s_uv), .input_sense_above_ov(s_ov),
    .vin_above_ov_trip(v_trip), .vin_above_ov_release(v_rel),
    .battery_current_set_open(bset_open), .input_current_set_open(iset_open),
    .battery_cc_current_lower(batt_lower), .led_variant_on_charging(led_var),
    .ovs_variant(ovs_var), .current_cmd(current_cmd),
    .half_current(half_current), .throttle_input(throttle_input),
    .led_on(led_on), .charge_full(charge_full), .standby(standby),
    .ntc_source_en(ntc_source_en));

  // ---------------------------------------------------------------
  // clock and hang guard
  // ---------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // a stuck state machine must not keep the run alive
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    results();
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [2:0] seen,
                       input logic [2:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // two sync edges plus state and output, with margin
  task automatic settle();
    repeat (8) @(posedge mclk);
    #1;
  endtask
  // bounded wait for full, counting paused cycles on the way
  task automatic wait_full(input int bound);
    int n;
    n = 0;
    paused = 0;
    while (charge_full !== 1'b1 && n < bound) begin
      if (current_cmd === charge_ctl_pkg::CUR_OFF) paused++;
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= bound) begin
      fail_count++;
      $display("[ERR] charge_full expected 1 seen timeout");
      results();
    end
  endtask
  // watch the indicator for a while
  task automatic watch_led(input int n);
    logic last;
    last = led_on;
    ones = 0;
    togs = 0;
    repeat (n) begin
      @(posedge mclk);
      #1;
      if (led_on === 1'b1) ones++;
      if (led_on !== last) togs++;
      last = led_on;
    end
  endtask
  // constant-current command expected from the setting straps
  function automatic logic [2:0] exp_cc();
    if (bset_open || iset_open) return charge_ctl_pkg::CUR_OFF;
    return batt_lower ? charge_ctl_pkg::CUR_BATT_SET
                      : charge_ctl_pkg::CUR_INPUT_SET;
  endfunction
  // reset with a chosen led strap; feedback low so precharge is entered
  task automatic start(input logic variant);
    reset_n = 1'b0;
    led_var = variant;
    fb_mv = 1000;
    repeat (3) @(posedge mclk);
    #1;
    check("ntc_source_en", 3'(ntc_source_en), 3'h0);
    reset_n = 1'b1;
    settle();
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {fail_count, num_checks} = 0;
    {reset_n, bset_open, iset_open, ovs_var, led_var, lfp} = '0;
    {fb_mv, temp_c, sense_mv, vin_mv} = {32'd1000, 32'd25, 32'd1800,
                                         32'd12000};
    batt_lower = 1'b1;
    void'($urandom(69));
    #1;
    start(1'b0);
    check("ntc_source_en", 3'(ntc_source_en), 3'h1);
    check("trickle cmd", current_cmd, charge_ctl_pkg::CUR_TRICKLE);
    sense_mv = 1200;
    settle();
    check("standby", 3'(standby), 3'h1);
    check("standby cmd", current_cmd, charge_ctl_pkg::CUR_OFF);
    sense_mv = 1800;
    settle();
    check("standby", 3'(standby), 3'h0);
    $display("test trickle and standby done");
    // random straps in constant current, open pins included
    fb_mv = 1800;
    for (int i = 0; i < 12; i++) begin
      batt_lower = 1'($urandom_range(1, 0));
      bset_open = ($urandom_range(3, 0) == 0);
      iset_open = ($urandom_range(3, 0) == 0);
      settle();
      check("cc cmd", current_cmd, exp_cc());
    end
    {bset_open, iset_open} = 2'b00;
    $display("test current select done");
    // thermistor zones, both boundaries of the normal zone
    temp_c = 50;
    settle();
    check("half_current", 3'(half_current), 3'h1);
    check("warm cmd", current_cmd, exp_cc());
    temp_c = 70;
    settle();
    check("hot cmd", current_cmd, charge_ctl_pkg::CUR_OFF);
    temp_c = 45;
    settle();
    check("half_current", 3'(half_current), 3'h0);
    temp_c = -20;
    settle();
    check("cold cmd", current_cmd, charge_ctl_pkg::CUR_OFF);
    temp_c = -10;
    settle();
    check("cold exit cmd", current_cmd, exp_cc());
    $display("test thermistor done");
    // input throttle and overvoltage with hysteresis
    sense_mv = 1400;
    settle();
    check("throttle_input", 3'(throttle_input), 3'h1);
    check("standby", 3'(standby), 3'h0);
    sense_mv = 1800;
    settle();
    check("throttle_input", 3'(throttle_input), 3'h0);
    vin_mv = 28000;
    settle();
    check("ov cmd", current_cmd, charge_ctl_pkg::CUR_OFF);
    vin_mv = 26000;
    settle();
    check("ov hold cmd", current_cmd, charge_ctl_pkg::CUR_OFF);
    vin_mv = 24000;
    settle();
    check("ov release cmd", current_cmd, exp_cc());
    ovs_var = 1'b1;
    sense_mv = 2700;
    settle();
    check("ovs cmd", current_cmd, charge_ctl_pkg::CUR_OFF);
    sense_mv = 1800;
    settle();
    check("ovs release cmd", current_cmd, exp_cc());
    ovs_var = 1'b0;
    settle();
    watch_led(4 * BLINK);
    check("led blinks", 3'(togs == 4 && ones == 2 * BLINK), 3'h1);
    $display("test input side done");
    // constant voltage, then a pause that finds the battery low
    fb_mv = 2100;
    settle();
    check("cv cmd", current_cmd, exp_cc());
    fb_mv = 2060;
    repeat (CV_P + 30) @(posedge mclk);
    #1;
    check("resume full", 3'(charge_full), 3'h0);
    check("resume cmd", current_cmd, exp_cc());
    fb_mv = 2100;
    wait_full(2 * CV_P + 60);
    check("pause seen", 3'(paused > 0), 3'h1);
    check("full cmd", current_cmd, charge_ctl_pkg::CUR_OFF);
    watch_led(4 * BLINK);
    check("led steady", 3'(ones == 4 * BLINK), 3'h1);
    fb_mv = 2060;
    settle();
    check("full hold", 3'(charge_full), 3'h1);
    fb_mv = 2000;
    settle();
    settle();
    check("recharge full", 3'(charge_full), 3'h0);
    check("recharge cmd", current_cmd, exp_cc());
    $display("test full cycle done");
    // indicator variant: on while charging, off when full
    start(1'b1);
    fb_mv = 1800;
    settle();
    watch_led(4 * BLINK);
    check("led on charging", 3'(ones == 4 * BLINK), 3'h1);
    fb_mv = 2100;
    wait_full(2 * CV_P + 60);
    settle();
    check("led off full", 3'(led_on), 3'h0);
    $display("test led variant done");
    // iron-phosphate thresholds move the trickle boundary down
    lfp = 1'b1;
    fb_mv = 1400;
    settle();
    check("lfp cc cmd", current_cmd, exp_cc());
    fb_mv = 1300;
    settle();
    check("lfp trickle cmd", current_cmd, charge_ctl_pkg::CUR_TRICKLE);
    $display("test lfp thresholds done");
    results();
  end
endmodule
